// ==== design/dsc_regs.svh ====
// Register offsets, field positions, reset values and timing counts for
// the converter self-calibration and gain trim block.
// Assumes inclusion by bare name from the package; the top module only uses its macros.
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH

`define DSC_ADDR_I_FINE_GAIN     7'h03
`define DSC_ADDR_I_COARSE_GAIN   7'h04
`define DSC_ADDR_I_CM_RESISTOR   7'h05
`define DSC_ADDR_Q_FINE_GAIN     7'h06
`define DSC_ADDR_Q_COARSE_GAIN   7'h07
`define DSC_ADDR_Q_CM_RESISTOR   7'h08
`define DSC_ADDR_REFERENCE_TRIM  7'h0d
`define DSC_ADDR_CAL_CONTROL     7'h0e
`define DSC_ADDR_CAL_STATUS      7'h0f
`define DSC_ADDR_COEF_ADDRESS    7'h10
`define DSC_ADDR_COEF_DATA       7'h11
`define DSC_ADDR_CAL_MEM_CONTROL 7'h12

// Calibration control fields
`define DSC_CAL_CLOCK_DIVIDER_SELECT_MSB           2
`define DSC_CAL_CLOCK_DIVIDER_SELECT_LSB           0
`define DSC_BIT_CAL_CLK_EN       3
`define DSC_BIT_SEL_I            4
`define DSC_BIT_SEL_Q            5
// Calibration memory control fields
`define DSC_BIT_UNCAL_Q          0
`define DSC_BIT_UNCAL_I          1
`define DSC_BIT_COEF_RD          2
`define DSC_BIT_COEF_WR          3
`define DSC_BIT_CAL_START        4
// Status fields
`define DSC_BIT_DONE_I           6
`define DSC_BIT_DONE_Q           7
// Common-mode resistor connect bit inside each resistor register
`define DSC_BIT_CM_ENABLE        6

`define DSC_REG_RESET            8'h00

// Timing
`define DSC_PRESCALE             16
`define DSC_COEF_COUNT           32
`define DSC_TICKS_PER_COEF       8
`define DSC_FIRST_COEF_ADDR      7'h01
`define DSC_LAST_COEF_ADDR       7'h20
`define DSC_SPI_HDR_BITS         8
`define DSC_SPI_FRAME_BITS       16

`endif

// ==== design/dsc_pkg.sv ====
// Types shared by the self-calibration and gain trim block.
// Assumes the constants header sits beside it.
package dsc_pkg;
  `include "dsc_regs.svh"

  typedef enum logic [1:0] {
    DSC_IDLE,
    DSC_RUN,
    DSC_DONE
  } dsc_cal_state_t;

  typedef struct packed {
    logic [5:0] reference_trim;
    logic [5:0] i_fine_gain_field;
    logic [5:0] i_coarse_gain_field;
    logic [5:0] i_cm_resistor_field;
    logic       i_cm_enable;
    logic [5:0] q_fine_gain_field;
    logic [5:0] q_coarse_gain_field;
    logic [5:0] q_cm_resistor_field;
    logic       q_cm_enable;
  } dsc_trim_t;

  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic       sdi;
  } dsc_spi_in_t;
endpackage

// ==== design/dsc_top.sv ====
// Serial register port, calibration clock divider, two calibration
// engines with coefficient memories, and gain trim registers.
// Assumes all pins synchronous to core_clk; serial clock well below it.

module dsc_cal_engine (
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 tick,
  input  wire logic                 start,
  input  wire logic [5:0]           measure,
  input  wire logic                 host_we,
  input  wire logic [4:0]           host_idx,
  input  wire logic [5:0]           host_data,
  input  wire logic [4:0]           rd_idx,
  output logic      [5:0]           rd_data,
  output logic                      done
);
  import dsc_pkg::*;

  dsc_cal_state_t state;
  logic [7:0]     step;
  logic [5:0]     coef [`DSC_COEF_COUNT];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= DSC_IDLE;
      step  <= 8'h00;
    end else begin
      case (state)
        DSC_IDLE: begin
          step <= 8'h00;
          if (start) begin
            state <= DSC_RUN;
          end
        end
        DSC_RUN: begin
          if (!start) begin
            state <= DSC_IDLE;
          end else if (tick) begin
            step <= step + 8'h01;
            if (step == 8'hff) begin
              state <= DSC_DONE;
            end
          end
        end
        default: begin
          if (!start) begin
            state <= DSC_IDLE;
          end
        end
      endcase
    end
  end

  // Self-calibration settles each coefficient over several ticks before
  // storing; a host write in the same cycle takes priority.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < `DSC_COEF_COUNT; k++) begin
        coef[k] <= 6'h00;
      end
    end else if (host_we) begin
      coef[host_idx] <= host_data;
    end else if (state == DSC_RUN && tick && start && step[2:0] == 3'h7) begin
      coef[step[7:3]] <= measure;
    end
  end

  assign rd_data = coef[rd_idx];
  assign done    = (state == DSC_DONE);
endmodule

module dsc_top (
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire dsc_pkg::dsc_spi_in_t spi_in,
  output logic                      spi_sdo,
  output logic                      spi_sdo_oe,
  input  wire logic [5:0]           i_cal_measure,
  input  wire logic [5:0]           q_cal_measure,
  output logic                      cal_clk_tick,
  output logic                      i_channel_cal_done,
  output logic                      q_channel_cal_done,
  output dsc_pkg::dsc_trim_t        trim
);
  import dsc_pkg::*;

  logic [7:0] i_fine_gain, i_coarse_gain, i_common_mode_resistor;
  logic [7:0] q_fine_gain, q_coarse_gain, q_common_mode_resistor;
  logic [7:0] reference_trim, calibration_control, coefficient_address;
  logic [7:0] coefficient_data, calibration_memory_control;

  logic       sclk_q;
  logic [4:0] bit_cnt;
  logic [15:0] shift_in;
  logic [7:0] tx;
  logic       is_read;
  logic       wr_pulse;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic       sclk_rise, sclk_fall;

  logic [3:0] pre_cnt;
  logic [7:0] post_cnt;
  logic [7:0] post_last;

  logic       coef_ok;
  logic [4:0] coef_idx;
  logic [5:0] i_rd, q_rd;
  logic       i_done, q_done;
  logic       i_host_we, q_host_we;

  wire  [2:0] cal_clock_divider_select =
    calibration_control[`DSC_CAL_CLOCK_DIVIDER_SELECT_MSB:`DSC_CAL_CLOCK_DIVIDER_SELECT_LSB];
  wire        cal_clock_enable     = calibration_control[`DSC_BIT_CAL_CLK_EN];
  wire        i_channel_cal_select = calibration_control[`DSC_BIT_SEL_I];
  wire        q_channel_cal_select = calibration_control[`DSC_BIT_SEL_Q];
  wire        coef_read_strobe  = calibration_memory_control[`DSC_BIT_COEF_RD];
  wire        coef_write_strobe = calibration_memory_control[`DSC_BIT_COEF_WR];
  wire        cal_start = calibration_memory_control[`DSC_BIT_CAL_START];

  // Serial port: 16-bit frames, MSB first, read flag, 7-bit address, data
  assign sclk_rise = spi_in.sclk & ~sclk_q;
  assign sclk_fall = ~spi_in.sclk & sclk_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q   <= 1'b0;
      bit_cnt  <= 5'h00;
      shift_in <= 16'h0000;
      is_read  <= 1'b0;
      wr_pulse <= 1'b0;
      wr_addr  <= 7'h00;
      wr_data  <= 8'h00;
    end else begin
      sclk_q   <= spi_in.sclk;
      wr_pulse <= 1'b0;
      if (spi_in.cs_n) begin
        bit_cnt <= 5'h00;
        is_read <= 1'b0;
      end else if (sclk_rise && bit_cnt < 5'd16) begin
        shift_in <= {shift_in[14:0], spi_in.sdi};
        bit_cnt  <= bit_cnt + 5'h01;
        if (bit_cnt == 5'd7) begin
          is_read <= shift_in[6];
        end
        if (bit_cnt == 5'd15 && !shift_in[14]) begin
          wr_pulse <= 1'b1;
          wr_addr  <= shift_in[13:7];
          wr_data  <= {shift_in[6:0], spi_in.sdi};
        end
      end
    end
  end

  function automatic logic [7:0] reg_read(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == `DSC_ADDR_I_FINE_GAIN) begin
      v = i_fine_gain;
    end else if (a == `DSC_ADDR_I_COARSE_GAIN) begin
      v = i_coarse_gain;
    end else if (a == `DSC_ADDR_I_CM_RESISTOR) begin
      v = i_common_mode_resistor;
    end else if (a == `DSC_ADDR_Q_FINE_GAIN) begin
      v = q_fine_gain;
    end else if (a == `DSC_ADDR_Q_COARSE_GAIN) begin
      v = q_coarse_gain;
    end else if (a == `DSC_ADDR_Q_CM_RESISTOR) begin
      v = q_common_mode_resistor;
    end else if (a == `DSC_ADDR_REFERENCE_TRIM) begin
      v = reference_trim;
    end else if (a == `DSC_ADDR_CAL_CONTROL) begin
      v = calibration_control;
    end else if (a == `DSC_ADDR_CAL_STATUS) begin
      v = {q_done, i_done, 6'h00};
    end else if (a == `DSC_ADDR_COEF_ADDRESS) begin
      v = coefficient_address;
    end else if (a == `DSC_ADDR_COEF_DATA) begin
      // I wins when both channels are selected for a read
      if (coef_read_strobe && coef_ok) begin
        v = {2'b00, i_channel_cal_select ? i_rd : q_rd};
      end else begin
        v = coefficient_data;
      end
    end else if (a == `DSC_ADDR_CAL_MEM_CONTROL) begin
      v = calibration_memory_control;
    end
    return v;
  endfunction

  // Read data is fetched after the header and shifted on falling edges
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx <= 8'h00;
    end else if (!spi_in.cs_n && sclk_rise && bit_cnt == 5'd7) begin
      tx <= reg_read({shift_in[5:0], spi_in.sdi});
    end else if (!spi_in.cs_n && sclk_fall && bit_cnt >= 5'd9) begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  assign spi_sdo    = tx[7];
  assign spi_sdo_oe = !spi_in.cs_n && is_read && bit_cnt >= 5'd8;

  // Plain trim and control registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      i_fine_gain            <= `DSC_REG_RESET;
      i_coarse_gain          <= `DSC_REG_RESET;
      i_common_mode_resistor <= `DSC_REG_RESET;
      q_fine_gain            <= `DSC_REG_RESET;
      q_coarse_gain          <= `DSC_REG_RESET;
      q_common_mode_resistor <= `DSC_REG_RESET;
      reference_trim         <= `DSC_REG_RESET;
      calibration_control    <= `DSC_REG_RESET;
      coefficient_address    <= `DSC_REG_RESET;
      coefficient_data       <= `DSC_REG_RESET;
    end else if (wr_pulse) begin
      if (wr_addr == `DSC_ADDR_I_FINE_GAIN) begin
        i_fine_gain <= wr_data;
      end else if (wr_addr == `DSC_ADDR_I_COARSE_GAIN) begin
        i_coarse_gain <= wr_data;
      end else if (wr_addr == `DSC_ADDR_I_CM_RESISTOR) begin
        i_common_mode_resistor <= wr_data;
      end else if (wr_addr == `DSC_ADDR_Q_FINE_GAIN) begin
        q_fine_gain <= wr_data;
      end else if (wr_addr == `DSC_ADDR_Q_COARSE_GAIN) begin
        q_coarse_gain <= wr_data;
      end else if (wr_addr == `DSC_ADDR_Q_CM_RESISTOR) begin
        q_common_mode_resistor <= wr_data;
      end else if (wr_addr == `DSC_ADDR_REFERENCE_TRIM) begin
        reference_trim <= wr_data;
      end else if (wr_addr == `DSC_ADDR_CAL_CONTROL) begin
        calibration_control <= wr_data;
      end else if (wr_addr == `DSC_ADDR_COEF_ADDRESS) begin
        coefficient_address <= wr_data;
      end else if (wr_addr == `DSC_ADDR_COEF_DATA) begin
        coefficient_data <= wr_data;
      end
    end
  end

  // Uncalibrate flags mark a channel whose memory the host overwrote;
  // a hardware set wins over a clearing write in the same cycle.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      calibration_memory_control <= `DSC_REG_RESET;
    end else begin
      if (wr_pulse && wr_addr == `DSC_ADDR_CAL_MEM_CONTROL) begin
        calibration_memory_control <= wr_data;
      end
      if (i_host_we) begin
        calibration_memory_control[`DSC_BIT_UNCAL_I] <= 1'b1;
      end
      if (q_host_we) begin
        calibration_memory_control[`DSC_BIT_UNCAL_Q] <= 1'b1;
      end
    end
  end

  // Coefficient addresses run from one to 32; others are ignored
  assign coef_ok  = coefficient_address[6:0] >= `DSC_FIRST_COEF_ADDR &&
                    coefficient_address[6:0] <= `DSC_LAST_COEF_ADDR &&
                    !coefficient_address[7];
  assign coef_idx = 5'(coefficient_address - 8'h01);
  assign i_host_we = wr_pulse && wr_addr == `DSC_ADDR_COEF_DATA &&
                     coef_write_strobe && coef_ok &&
                     i_channel_cal_select;
  assign q_host_we = wr_pulse && wr_addr == `DSC_ADDR_COEF_DATA &&
                     coef_write_strobe && coef_ok &&
                     q_channel_cal_select;

  // Divider: 16 sample clocks, then 2 to 256 prescaled periods
  assign post_last = 8'((9'h002 << cal_clock_divider_select) - 9'h001);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt  <= 4'h0;
      post_cnt <= 8'h00;
    end else if (!cal_clock_enable) begin
      pre_cnt  <= 4'h0;
      post_cnt <= 8'h00;
    end else begin
      pre_cnt <= pre_cnt + 4'h1;
      if (pre_cnt == 4'(`DSC_PRESCALE - 1)) begin
        post_cnt <= (post_cnt >= post_last) ? 8'h00 : post_cnt + 8'h01;
      end
    end
  end

  assign cal_clk_tick = cal_clock_enable &&
                        pre_cnt == 4'(`DSC_PRESCALE - 1) &&
                        post_cnt >= post_last;

  dsc_cal_engine u_cal_i (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .tick      (cal_clk_tick),
    .start     (cal_start && i_channel_cal_select),
    .measure   (i_cal_measure),
    .host_we   (i_host_we),
    .host_idx  (coef_idx),
    .host_data (wr_data[5:0]),
    .rd_idx    (coef_idx),
    .rd_data   (i_rd),
    .done      (i_done)
  );

  dsc_cal_engine u_cal_q (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .tick      (cal_clk_tick),
    .start     (cal_start && q_channel_cal_select),
    .measure   (q_cal_measure),
    .host_we   (q_host_we),
    .host_idx  (coef_idx),
    .host_data (wr_data[5:0]),
    .rd_idx    (coef_idx),
    .rd_data   (q_rd),
    .done      (q_done)
  );

  assign i_channel_cal_done = i_done;
  assign q_channel_cal_done = q_done;

  // Trim fields drive the analog side straight from the registers
  assign trim.reference_trim      = reference_trim[5:0];
  assign trim.i_coarse_gain_field = i_coarse_gain[5:0];
  assign trim.q_coarse_gain_field = q_coarse_gain[5:0];
  assign trim.i_fine_gain_field   = i_fine_gain[5:0];
  assign trim.q_fine_gain_field   = q_fine_gain[5:0];
  assign trim.i_cm_resistor_field = i_common_mode_resistor[5:0];
  assign trim.q_cm_resistor_field = q_common_mode_resistor[5:0];
  assign trim.i_cm_enable =
    i_common_mode_resistor[`DSC_BIT_CM_ENABLE];
  assign trim.q_cm_enable =
    q_common_mode_resistor[`DSC_BIT_CM_ENABLE];
endmodule

// ==== verif/dsc_top_properties.sv ====
// Port-level checks for the self-calibration and gain trim block.
// Assumes it is bound to dsc_top and sees nothing but its ports.
module dsc_top_properties (
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire dsc_pkg::dsc_spi_in_t spi_in,
  input  wire logic                 spi_sdo,
  input  wire logic                 spi_sdo_oe,
  input  wire logic [5:0]           i_cal_measure,
  input  wire logic [5:0]           q_cal_measure,
  input  wire logic                 cal_clk_tick,
  input  wire logic                 i_channel_cal_done,
  input  wire logic                 q_channel_cal_done,
  input  wire dsc_pkg::dsc_trim_t   trim
);
  timeunit 1ns;
  timeprecision 1ns;
  import dsc_pkg::*;

  logic        prev_sclk;
  logic [4:0]  rise_cnt;
  logic [11:0] gap_cnt;
  logic [8:0]  tick_cnt;
  logic [3:0]  idle_cnt;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prev_sclk <= 1'b0;
      rise_cnt  <= 5'h00;
    end else begin
      prev_sclk <= spi_in.sclk;
      if (spi_in.cs_n) begin
        rise_cnt <= 5'h00;
      end else if (spi_in.sclk && !prev_sclk && rise_cnt != 5'h1f) begin
        rise_cnt <= rise_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gap_cnt <= 12'h000;
    end else if (cal_clk_tick) begin
      gap_cnt <= 12'h000;
    end else if (gap_cnt != 12'hfff) begin
      gap_cnt <= gap_cnt + 12'h001;
    end
  end

  // Ticks since the last frame; the start write is the last frame before
  // a run, so a run cannot finish with fewer ticks than this count
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 9'h000;
    end else if (!spi_in.cs_n) begin
      tick_cnt <= 9'h000;
    end else if (cal_clk_tick && tick_cnt != 9'h1ff) begin
      tick_cnt <= tick_cnt + 9'h001;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      idle_cnt <= 4'h0;
    end else if (!spi_in.cs_n) begin
      idle_cnt <= 4'h0;
    end else if (idle_cnt != 4'hf) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_frame_end;
    $rose(spi_in.cs_n);
  endsequence

  sequence s_write_landed;
    rise_cnt == 5'h10 && !spi_in.cs_n;
  endsequence

  a_tick_spacing: assert property (
    cal_clk_tick |-> gap_cnt >= 12'h01f)
    else $error("calibration ticks closer than 32 cycles");
  a_i_done_ticks: assert property (
    $rose(i_channel_cal_done) |-> tick_cnt >= 9'h0fe)
    else $error("I done raised too early");
  a_q_done_ticks: assert property (
    $rose(q_channel_cal_done) |-> tick_cnt >= 9'h0fe)
    else $error("Q done raised too early");
  a_i_done_hold: assert property (
    $fell(i_channel_cal_done) |-> idle_cnt < 4'h8)
    else $error("I done dropped without a register write");
  a_q_done_hold: assert property (
    $fell(q_channel_cal_done) |-> idle_cnt < 4'h8)
    else $error("Q done dropped without a register write");
  a_oe_header: assert property (
    $rose(spi_sdo_oe) |-> rise_cnt == 5'h08 && !spi_in.cs_n)
    else $error("read data driven before eight header bits");
  a_oe_release: assert property (
    s_frame_end |-> ##2 !spi_sdo_oe [*2])
    else $error("read data still driven after frame end");
  a_trim_on_frame: assert property (
    $changed(trim) |-> s_write_landed)
    else $error("trim changed outside a complete write frame");
endmodule

bind dsc_top dsc_top_properties chk_u (
  .core_clk           (core_clk),
  .nrst               (nrst),
  .spi_in             (spi_in),
  .spi_sdo            (spi_sdo),
  .spi_sdo_oe         (spi_sdo_oe),
  .i_cal_measure      (i_cal_measure),
  .q_cal_measure      (q_cal_measure),
  .cal_clk_tick       (cal_clk_tick),
  .i_channel_cal_done (i_channel_cal_done),
  .q_channel_cal_done (q_channel_cal_done),
  .trim               (trim)
);

// ==== verif/dsc_host_model.sv ====
// Host controller model driving the serial register port.
// Assumes sclk phases of three core clocks, well above the two needed.
module dsc_host_model (
  input  wire logic            core_clk,
  input  wire logic            spi_sdo,
  input  wire logic            spi_sdo_oe,
  output dsc_pkg::dsc_spi_in_t spi_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import dsc_pkg::*;

  initial spi_in = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};

  // Data line keeps changing between frames so no stale bit looks valid
  always @(posedge core_clk) begin
    if (spi_in.cs_n) spi_in.sdi <= ~spi_in.sdi;
  end

  // Read data is taken just before each rising sclk; the device launches the first bit on the eighth rising sclk, the rest on falling sclk
  task automatic xfer(input  logic       rd,
                      input  logic [6:0] a,
                      input  logic [7:0] d,
                      input  int         nbits,
                      output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, d};
    q = 8'h00;
    @(posedge core_clk) spi_in.cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(posedge core_clk) begin
        spi_in.sdi  <= f[15 - i];
        spi_in.sclk <= 1'b0;
      end
      repeat (3) @(posedge core_clk);
      // A released data line reads inverted, so a missing enable shows up
      if (i >= 8) q = {q[6:0], spi_sdo_oe ? spi_sdo : ~spi_sdo};
      spi_in.sclk <= 1'b1;
      repeat (2) @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
    @(posedge core_clk) begin
      spi_in.sclk <= 1'b0;
      spi_in.cs_n <= 1'b1;
    end
    repeat (3) @(posedge core_clk);
  endtask
endmodule

// ==== verif/dac_self_cal_and_gain_control_test.sv ====
// Self-checking bench for the self-calibration and gain trim block.
// Assumes dsc_top, its bound checker and the host model are compiled.
module dac_self_cal_and_gain_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import dsc_pkg::*;

  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  dsc_spi_in_t spi_in;
  logic        spi_sdo;
  logic        spi_sdo_oe;
  logic [5:0]  i_cal_measure = 6'h2a;
  logic [5:0]  q_cal_measure = 6'h15;
  logic        cal_clk_tick;
  logic        i_done;
  logic        q_done;
  dsc_trim_t   trim;
  dsc_trim_t   et;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          n;
  logic [7:0]  v;
  logic [7:0]  q;
  logic [6:0]  ta [7] = '{7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h0d};

  always #50 core_clk = ~core_clk;

  dsc_top dut_u (
    .core_clk           (core_clk),
    .nrst               (nrst),
    .spi_in             (spi_in),
    .spi_sdo            (spi_sdo),
    .spi_sdo_oe         (spi_sdo_oe),
    .i_cal_measure      (i_cal_measure),
    .q_cal_measure      (q_cal_measure),
    .cal_clk_tick       (cal_clk_tick),
    .i_channel_cal_done (i_done),
    .q_channel_cal_done (q_done),
    .trim               (trim)
  );

  dsc_host_model host_u (
    .core_clk   (core_clk),
    .spi_sdo    (spi_sdo),
    .spi_sdo_oe (spi_sdo_oe),
    .spi_in     (spi_in)
  );

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    host_u.xfer(1'b0, a, d, 16, r);
  endtask

  task automatic rd_chk(input string what, input logic [6:0] a,
                        input logic [7:0] e);
    logic [7:0] r;
    host_u.xfer(1'b1, a, 8'h00, 16, r);
    check(what, 64'(r), 64'(e));
  endtask

  // Gives up after 5000 cycles so a dead divider reads as 5000
  task automatic next_tick(output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (cal_clk_tick !== 1'b1 && c < 5000);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    et = '0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    check("trim at reset", 64'(trim), 64'h0);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 7; i++) begin
        v = p ? 8'h20 : 8'h1f;
        if (ta[i] == 7'h05 || ta[i] == 7'h08) v = v | 8'h40;
        wr(ta[i], v);
        case (ta[i])
          7'h03: et.i_fine_gain_field = v[5:0];
          7'h04: et.i_coarse_gain_field = v[5:0];
          7'h05: begin
            et.i_cm_resistor_field = v[5:0];
            et.i_cm_enable = 1'b1;
          end
          7'h06: et.q_fine_gain_field = v[5:0];
          7'h07: et.q_coarse_gain_field = v[5:0];
          7'h08: begin
            et.q_cm_resistor_field = v[5:0];
            et.q_cm_enable = 1'b1;
          end
          default: et.reference_trim = v[5:0];
        endcase
        check("trim fields", 64'(trim), 64'(et));
        rd_chk("trim readback", ta[i], v);
      end
    end
    host_u.xfer(1'b0, 7'h03, 8'h3c, 10, q);
    rd_chk("aborted write", 7'h03, 8'h20);
    wr(7'h0f, 8'hff);
    rd_chk("status", 7'h0f, 8'h00);
    rd_chk("unmapped", 7'h7f, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(7'h0e, 8'h08 | 8'(s));
      next_tick(n);
      next_tick(n);
      check("cal period", 64'(n), 64'(32 << s));
      wr(7'h0e, 8'h00);
    end
    next_tick(n);
    check("tick while off", 64'(n), 64'h1388);
    // A 10 MHz core cannot reach the preferred calibration rate at all
    wr(7'h12, 8'h00);
    wr(7'h0e, 8'h18);
    wr(7'h12, 8'h10);
    repeat (300 * 32) @(posedge core_clk);
    rd_chk("status", 7'h0f, 8'h40);
    check("done pins", 64'({i_done, q_done}), 64'h2);
    repeat (1000) @(posedge core_clk);
    rd_chk("status held", 7'h0f, 8'h40);
    wr(7'h12, 8'h00);
    rd_chk("status cleared", 7'h0f, 8'h00);
    wr(7'h0e, 8'h39);
    wr(7'h12, 8'h10);
    repeat (300 * 64) @(posedge core_clk);
    rd_chk("status", 7'h0f, 8'hc0);
    wr(7'h12, 8'h00);
    wr(7'h0e, 8'h30);
    for (int k = 0; k < 2; k++) begin
      wr(7'h0e, k ? 8'h20 : 8'h10);
      wr(7'h10, k ? 8'h20 : 8'h01);
      wr(7'h12, 8'h04);
      rd_chk("coefficient", 7'h11, k ? 8'h15 : 8'h2a);
      wr(7'h12, 8'h00);
    end
    wr(7'h12, 8'h08);
    wr(7'h10, 8'h05);
    wr(7'h11, 8'h33);
    rd_chk("uncal flag", 7'h12, 8'h09);
    wr(7'h12, 8'h00);
    rd_chk("flags cleared", 7'h12, 8'h00);
    wr(7'h12, 8'h04);
    rd_chk("coef written", 7'h11, 8'h33);
    wr(7'h10, 8'h06);
    rd_chk("coef neighbour", 7'h11, 8'h15);
    wr(7'h0e, 8'h30);
    wr(7'h12, 8'h08);
    wr(7'h10, 8'h07);
    wr(7'h11, 8'h2e);
    rd_chk("both uncal flags", 7'h12, 8'h0b);
    wr(7'h12, 8'h04);
    rd_chk("I coef written", 7'h11, 8'h2e);
    wr(7'h0e, 8'h20);
    rd_chk("Q coef written", 7'h11, 8'h2e);
    wr(7'h12, 8'h00);
    wr(7'h0e, 8'h00);
    end_sim();
  end
endmodule
